/* File: sio_top.sv */
// Safety I/O pins, fail-safe and reset outputs, debug strap and interrupt pulse.
// Assumes configuration ports come from SPI logic on sys_clk; pins and
// comparator results are asynchronous.
`timescale 1ns/1ps
`include "sio_cfg.svh"
module sio_top #(
    parameter int CNT_W = 24,
    parameter int RST_SHORT_CYC = `SIO_T_RST_SHORT_US * (`SIO_CLK_HZ / 1000000),
    parameter int RST_MID_CYC = `SIO_T_RST_MID_US * (`SIO_CLK_HZ / 1000000),
    parameter int RST_LONG_CYC = `SIO_T_RST_LONG_US * (`SIO_CLK_HZ / 1000000)
) (
    input wire logic sys_clk, // 20 MHz clock
    input wire logic nrst, // Async reset, active low
    input wire logic [5:0] io_pin_in, // Multipurpose pin levels
    input wire logic debug_win_in, // Strap comparator: inside debug window
    input wire logic fb_cmp_in, // Core feedback vs pin 1 beyond limit
    input wire logic [5:0] dig_en, // Pin used as digital input
    input wire logic [11:0] wake_cfg, // Two bits per pin, wake edge select
    input wire logic [5:0] wake_clr, // Clear wake flags
    input wire logic amux_wr, // Analog select write strobe
    input wire logic [2:0] amux_sel, // Analog select value
    input wire logic safe01_en, // Pins 0/1 monitor external IC
    input wire logic safe23_en, // Pins 2/3 monitor controller errors
    input wire logic safe45_en, // Pins 4/5 monitor external IC
    input wire logic fb_mon_en, // Pin 1 duplicates core feedback
    input wire logic [1:0] gate_en, // Pins 4/5 in gate driver mode
    input wire logic [1:0] gate_lvl, // Gate drive levels for pins 4/5
    input wire logic rst_dur_wr, // Reset duration write strobe
    input wire logic rst_dur_val, // 0: 1 ms, 1: 10 ms
    input wire logic int_cfg_wr, // Interrupt config write strobe
    input wire logic int_en_val, // Interrupt pulses enabled
    input wire logic [1:0] int_len_val, // Pulse length in units minus one
    input wire logic init_close, // Leave the init phase
    input wire logic wd_good, // Last watchdog answer was good
    input wire logic wd_error, // Watchdog error event
    input wire logic fs_release_wr, // Release write for fail-safe output
    input wire logic ext_fault, // Other qualifying fault event
    input wire logic ext_rst_req, // Other fault reset request
    output logic failsafe_output_n, // Fail-safe output, low active
    output logic reset_output_n, // Reset to controller, low active
    output logic interrupt_output_n, // Interrupt pulse, low active
    output logic [2:0] analog_select_output, // Selected analog source
    output logic reset_duration_config, // Stored reset duration
    output logic failsafe_init_phase, // Init phase open
    output logic wd_running, // Normal watchdog running state
    output logic [5:0] dig_in, // Digital pin levels
    output logic [5:0] wake_flag, // Sticky wake flags
    output logic [2:0] pair_err, // Pair errors: 0/1, 2/3, 4/5
    output logic fb_fault, // Core feedback mismatch
    output logic debug_mode, // Debug mode active
    output logic can_normal_req, // CAN transceiver to normal mode
    output logic [1:0] gate_drv_out, // Gate drive level, pins 4/5
    output logic [1:0] gate_drv_oe // Gate drive enable, pins 4/5
);
    localparam int INT_UNIT_CYC = `SIO_T_INT_UNIT_US * (`SIO_CLK_HZ / 1000000);

    // ****************************************************************
    // Input synchronisers and start-up sequence
    // ****************************************************************
    logic [5:0] io_s;
    logic dbg_s;
    logic fb_s;
    logic [2:0] start_sr_r;
    logic prev_vld_r;

    sio_sync #(.W(8)) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .d({fb_cmp_in, debug_win_in, io_pin_in}),
        .q({fb_s, dbg_s, io_s})
    );

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            start_sr_r <= 3'h1;
            prev_vld_r <= 1'b0;
        end else begin
            start_sr_r <= {start_sr_r[1:0], 1'b0};
            if (start_sr_r[2]) begin
                prev_vld_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Debug strap
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            debug_mode <= 1'b0;
            can_normal_req <= 1'b0;
        end else begin
            if (start_sr_r[2]) begin
                debug_mode <= dbg_s;
            end
            can_normal_req <= debug_mode;
        end
    end

    // ****************************************************************
    // Digital inputs and wake detection
    // ****************************************************************
    logic [5:0] prev_r;
    logic [5:0] wake_evt;

    for (genvar i = 0; i < 6; i++) begin : g_pin
        sio_pkg::sio_wake_t sel;
        assign sel = sio_pkg::sio_wake_t'(wake_cfg[i*`SIO_WAKE_FLD_W +: `SIO_WAKE_FLD_W]);
        assign wake_evt[i] = prev_vld_r && (
            (sel == sio_pkg::SIO_WK_RISE && io_s[i] && !prev_r[i]) ||
            (sel == sio_pkg::SIO_WK_FALL && !io_s[i] && prev_r[i]) ||
            (sel == sio_pkg::SIO_WK_CHANGE && io_s[i] != prev_r[i]));

        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                prev_r[i] <= 1'b0;
                dig_in[i] <= 1'b0;
                wake_flag[i] <= 1'b0;
            end else begin
                prev_r[i] <= io_s[i];
                dig_in[i] <= dig_en[i] & io_s[i];
                if (wake_evt[i]) begin
                    wake_flag[i] <= 1'b1;
                end else if (wake_clr[i]) begin
                    wake_flag[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Analog select and gate drivers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            analog_select_output <= sio_pkg::SIO_AMUX_BATT;
            gate_drv_out <= 2'h0;
            gate_drv_oe <= 2'h0;
        end else begin
            if (amux_wr && amux_sel <= sio_pkg::SIO_AMUX_TEMP) begin
                analog_select_output <= amux_sel;
            end
            gate_drv_oe <= gate_en;
            gate_drv_out <= gate_en & gate_lvl;
        end
    end

    // ****************************************************************
    // Safety pairs and core feedback monitor
    // ****************************************************************
    sio_pkg::sio_state_t state_r;
    sio_pkg::sio_state_t state_nxt;
    logic [2:0] pair_lvl;
    logic [2:0] pair_evt;
    logic fb_evt;

    assign pair_lvl[0] = safe01_en && io_s[0] == io_s[1];
    assign pair_lvl[1] = safe23_en && state_r == sio_pkg::SIO_ST_RUN
        && {io_s[3], io_s[2]} != `SIO_MCU_PAIR_NORMAL;
    assign pair_lvl[2] = safe45_en && io_s[4] == io_s[5];
    assign pair_evt = pair_lvl & ~pair_err;
    assign fb_evt = fb_mon_en && fb_s && !fb_fault;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pair_err <= 3'h0;
            fb_fault <= 1'b0;
        end else begin
            pair_err <= pair_lvl;
            fb_fault <= fb_mon_en & fb_s;
        end
    end

    // ****************************************************************
    // Fail-safe state and reset sequencing
    // ****************************************************************
    logic rst_req;
    logic fault_evt;
    logic tmr_load;
    logic tmr_done;
    logic [CNT_W-1:0] tmr_val;

    assign rst_req = ext_rst_req | (wd_error & ~debug_mode) | (|pair_evt);
    assign fault_evt = ext_fault | (wd_error & ~debug_mode) | (|pair_evt) | fb_evt;
    assign tmr_load = start_sr_r[0] ||
        (state_r != sio_pkg::SIO_ST_FLTRST && state_nxt == sio_pkg::SIO_ST_FLTRST);
    assign tmr_val = start_sr_r[0] ? CNT_W'(RST_LONG_CYC) :
        (reset_duration_config ? CNT_W'(RST_MID_CYC) : CNT_W'(RST_SHORT_CYC));

    sio_timer #(.CNT_W(CNT_W)) u_rst_tmr (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(tmr_load),
        .load_val(tmr_val),
        .busy(),
        .done(tmr_done)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sio_pkg::SIO_ST_PORRST: begin
                if (tmr_done) begin
                    state_nxt = sio_pkg::SIO_ST_INIT;
                end
            end
            sio_pkg::SIO_ST_INIT: begin
                if (rst_req) begin
                    state_nxt = sio_pkg::SIO_ST_FLTRST;
                end else if (init_close) begin
                    state_nxt = sio_pkg::SIO_ST_RUN;
                end
            end
            sio_pkg::SIO_ST_RUN: begin
                if (rst_req) begin
                    state_nxt = sio_pkg::SIO_ST_FLTRST;
                end
            end
            sio_pkg::SIO_ST_FLTRST: begin
                if (tmr_done) begin
                    state_nxt = sio_pkg::SIO_ST_INIT;
                end
            end
            default: begin
                state_nxt = sio_pkg::SIO_ST_PORRST;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= sio_pkg::SIO_ST_PORRST;
            reset_output_n <= 1'b0;
            failsafe_init_phase <= 1'b0;
            wd_running <= 1'b0;
        end else begin
            state_r <= state_nxt;
            reset_output_n <= state_nxt == sio_pkg::SIO_ST_INIT || state_nxt == sio_pkg::SIO_ST_RUN;
            failsafe_init_phase <= state_nxt == sio_pkg::SIO_ST_INIT;
            wd_running <= state_nxt == sio_pkg::SIO_ST_RUN;
        end
    end

    // ****************************************************************
    // Init-only configuration
    // ****************************************************************
    logic int_en_r;
    logic [1:0] int_len_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reset_duration_config <= `SIO_RST_DUR_RESET;
            int_en_r <= `SIO_INT_EN_RESET;
            int_len_r <= `SIO_INT_LEN_RESET;
        end else if (state_r == sio_pkg::SIO_ST_INIT) begin
            if (rst_dur_wr) begin
                reset_duration_config <= rst_dur_val;
            end
            if (int_cfg_wr) begin
                int_en_r <= int_en_val;
                int_len_r <= int_len_val;
            end
        end
    end

    // ****************************************************************
    // Fail-safe output
    // ****************************************************************
    logic released_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            failsafe_output_n <= 1'b0;
            released_r <= 1'b0;
        end else begin
            if (fault_evt && !(debug_mode && released_r)) begin
                failsafe_output_n <= 1'b0;
            end else if (fs_release_wr && wd_good) begin
                failsafe_output_n <= 1'b1;
                released_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Interrupt pulse
    // ****************************************************************
    logic int_load;
    logic int_busy;

    assign int_load = int_en_r && ((|wake_evt) || (|pair_evt) || fb_evt);

    sio_timer #(.CNT_W(CNT_W)) u_int_tmr (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(int_load),
        .load_val(CNT_W'((int'(int_len_r) + 1) * INT_UNIT_CYC)),
        .busy(int_busy),
        .done()
    );

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_output_n <= 1'b1;
        end else begin
            interrupt_output_n <= !int_busy;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    wake_rise_a: assert property (prev_vld_r && wake_cfg[1:0] == 2'h0 && io_s[0] && !prev_r[0]
        |=> wake_flag[0]) else $error("wake rise missed");
    dig_read_a: assert property (dig_en[0] |=> dig_in[0] == $past(io_s[0]))
        else $error("digital level not shown");
    amux_sel_a: assert property (amux_wr && amux_sel < 3'h5 |=> analog_select_output == $past(amux_sel))
        else $error("analog select not taken");
    ic_pair_a: assert property (safe45_en && io_s[4] == io_s[5] |=> pair_err[2])
        else $error("ic pair error missed");
    mcu_pair_a: assert property (state_r != sio_pkg::SIO_ST_RUN |=> !pair_err[1])
        else $error("mcu pair checked outside run");
    fb_mon_a: assert property (fb_mon_en && fb_s |=> fb_fault)
        else $error("feedback fault missed");
    gate_off_a: assert property (!gate_en[1] |=> !gate_drv_oe[1] && !gate_drv_out[1])
        else $error("gate driven when off");
    fs_fault_a: assert property (fault_evt && !(debug_mode && released_r) |=> !failsafe_output_n)
        else $error("fail-safe not asserted");
    fs_debug_a: assert property (debug_mode && released_r |=> failsafe_output_n)
        else $error("fail-safe asserted in debug");
    rst_lock_a: assert property (rst_dur_wr && state_r != sio_pkg::SIO_ST_INIT
        |=> $stable(reset_duration_config)) else $error("duration written outside init");
    rst_fault_a: assert property (state_r == sio_pkg::SIO_ST_RUN && rst_req |=> !reset_output_n[*2])
        else $error("fault reset not asserted");
    dbg_hold_a: assert property (!start_sr_r[2] |=> $stable(debug_mode))
        else $error("debug mode changed");

    run_c: cover property (state_r == sio_pkg::SIO_ST_RUN);
    fault_rst_c: cover property (state_r == sio_pkg::SIO_ST_FLTRST ##1 state_r == sio_pkg::SIO_ST_FLTRST);
    release_c: cover property ($rose(failsafe_output_n));
    int_pulse_c: cover property ($fell(interrupt_output_n));
endmodule : sio_top

/* File: sio_cfg.svh */
// Timing, reset values and pin-pair encodings for the safety I/O block.
// Assumes a single 20 MHz system clock; included by bare name.
`ifndef SIO_CFG_SVH
`define SIO_CFG_SVH

// ****************************************************************
// Clock and times
// ****************************************************************
`define SIO_CLK_HZ 20000000
`define SIO_T_RST_SHORT_US 1000
`define SIO_T_RST_MID_US 10000
`define SIO_T_RST_LONG_US 20000
`define SIO_T_INT_UNIT_US 25

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define SIO_RST_DUR_RESET 1'h0
`define SIO_INT_LEN_RESET 2'h0
`define SIO_INT_EN_RESET 1'h1
`define SIO_MCU_PAIR_NORMAL 2'h1
`define SIO_WAKE_FLD_W 2

`endif

/* File: sio_pkg.sv */
// Types shared by the safety I/O block.
// Assumes nothing of its surroundings.
package sio_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        SIO_ST_PORRST = 4'h1,
        SIO_ST_INIT = 4'h2,
        SIO_ST_RUN = 4'h4,
        SIO_ST_FLTRST = 4'h8
    } sio_state_t;

    typedef enum logic [1:0] {
        SIO_WK_RISE = 2'h0,
        SIO_WK_FALL = 2'h1,
        SIO_WK_CHANGE = 2'h2,
        SIO_WK_OFF = 2'h3
    } sio_wake_t;

    typedef enum logic [2:0] {
        SIO_AMUX_BATT = 3'h0,
        SIO_AMUX_IO0 = 3'h1,
        SIO_AMUX_IO1 = 3'h2,
        SIO_AMUX_REF = 3'h3,
        SIO_AMUX_TEMP = 3'h4
    } sio_amux_t;

endpackage : sio_pkg

/* File: sio_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
module sio_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic [W-1:0] d, // Asynchronous levels
    output logic [W-1:0] q // Synchronised levels
);
    logic [W-1:0] meta_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sio_sync

/* File: sio_timer.sv */
// Loadable down counter used for reset and interrupt pulse lengths.
// Assumes load values of one or more; a load restarts the count.
`timescale 1ns/1ps
module sio_timer #(
    parameter int CNT_W = 24
) (
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Async reset, active low
    input wire logic load, // Start counting from load_val
    input wire logic [CNT_W-1:0] load_val, // Cycles to count
    output logic busy, // Count running
    output logic done // Last counted cycle
);
    logic [CNT_W-1:0] cnt_r;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - CNT_W'(1);
        end
    end

    assign busy = cnt_r != '0;
    assign done = cnt_r == CNT_W'(1);
endmodule : sio_timer

/* File: sio_host_model.sv */
// Host controller model: measures reset pulses and releases the fail-safe output.
// Assumes the block's reset output and a bench request to release.
`timescale 1ns/1ps
module sio_host_model (
    input wire logic sys_clk, // System clock
    input wire logic reset_output_n, // Reset from the block
    input wire logic rel_req, // Bench asks for a release
    output logic wd_good, // Good watchdog answer
    output logic fs_release_wr, // Release write pulse
    output int rst_low_last // Cycles of the last reset pulse
);
    // ****************************************************************
    // Controller behaviour
    // ****************************************************************
    int cnt;
    logic pend;
    initial begin
        {wd_good, fs_release_wr, pend} = '0;
        cnt = 0;
        rst_low_last = 0;
    end
    always @(posedge sys_clk) begin
        if (!reset_output_n) begin
            cnt <= cnt + 1;
        end else begin
            if (cnt != 0) rst_low_last <= cnt;
            cnt <= 0;
        end
        // Held in reset it answers nothing; once free, good answer then release
        wd_good <= reset_output_n & (wd_good | rel_req);
        pend <= reset_output_n & rel_req;
        fs_release_wr <= pend & reset_output_n;
    end
endmodule : sio_host_model

/* File: sio_top_tb_top.sv */
// Testbench for the safety I/O block: boot, config, faults, wake, debug.
// Assumes sio_top and sio_host_model on one 20 MHz clock.
`timescale 1ns/1ps
module sio_top_tb_top;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic sys_clk, nrst, debug_win_in, fb_cmp_in, amux_wr, safe01_en, safe23_en, safe45_en, fb_mon_en;
    logic rst_dur_wr, rst_dur_val, int_cfg_wr, int_en_val, init_close, wd_good, wd_error, fs_release_wr;
    logic ext_fault, ext_rst_req, failsafe_output_n, reset_output_n, interrupt_output_n, reset_duration_config;
    logic failsafe_init_phase, wd_running, fb_fault, debug_mode, can_normal_req, rel_req;
    logic [5:0] io_pin_in, dig_en, wake_clr, dig_in, wake_flag;
    logic [11:0] wake_cfg;
    logic [2:0] amux_sel, analog_select_output, pair_err;
    logic [1:0] gate_en, gate_lvl, int_len_val, gate_drv_out, gate_drv_oe;
    int rst_low_last, fails, compares, n;
    sio_top #(.RST_SHORT_CYC(20), .RST_MID_CYC(40), .RST_LONG_CYC(60)) i_sio_top (.*);
    sio_host_model i_sio_host_model (.*);

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #5;
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask : tdone
    task automatic final_report;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic wait_rst;
        n = 0;
        while (reset_output_n !== 1'b1 && n < 500) begin
            cyc(1);
            n++;
        end
    endtask : wait_rst
    task automatic boot(input logic dbg);
        nrst = 1'b0;
        debug_win_in = dbg;
        cyc(10);
        nrst = 1'b1;
        chk(failsafe_output_n, 8'h0, "fs low after reset");
        wait_rst();
        chk(n >= 58 && n <= 66, 8'h1, "long reset");
        chk(failsafe_init_phase, 8'h1, "init phase");
    endtask : boot
    task automatic release_fs;
        pulse(rel_req);
        cyc(5);
        chk(failsafe_output_n, 8'h1, "release");
    endtask : release_fs

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        {nrst, debug_win_in, fb_cmp_in, amux_wr, safe01_en, safe23_en, safe45_en, fb_mon_en, rel_req} = '0;
        {rst_dur_wr, rst_dur_val, int_cfg_wr, int_en_val, init_close, wd_error, ext_fault, ext_rst_req} = '0;
        {dig_en, wake_clr, amux_sel, gate_en, gate_lvl, int_len_val} = '0;
        io_pin_in = 6'h02;
        wake_cfg = 12'hfff;
        {fails, compares} = '0;
        boot(1'b0);
        rst_dur_val = 1'b1;
        pulse(rst_dur_wr);
        chk(reset_duration_config, 8'h1, "duration in init");
        for (int i = 0; i < 6; i++) begin
            amux_sel = i[2:0];
            pulse(amux_wr);
            chk(analog_select_output, (i < 5) ? i[7:0] : 8'h4, "analog select");
            cyc(1);
        end
        int_en_val = 1'b1;
        pulse(int_cfg_wr);
        gate_en = 2'h3;
        gate_lvl = 2'h2;
        cyc(2);
        chk({gate_drv_oe, gate_drv_out}, 8'he, "gate drive");
        pulse(init_close);
        chk(wd_running, 8'h1, "run state");
        rst_dur_val = 1'b0;
        pulse(rst_dur_wr);
        chk(reset_duration_config, 8'h1, "duration locked");
        tdone("config");
        release_fs();
        pulse(ext_fault);
        cyc(1);
        chk(failsafe_output_n, 8'h0, "fault");
        {fb_mon_en, fb_cmp_in} = 2'h3;
        cyc(4);
        chk(fb_fault, 8'h1, "feedback");
        {fb_mon_en, fb_cmp_in} = 2'h0;
        release_fs();
        tdone("fail-safe");
        cyc(500);
        chk(interrupt_output_n, 8'h1, "interrupt ended");
        dig_en = 6'h3f;
        wake_cfg = 12'hfe4;
        wake_clr = 6'h3f;
        cyc(2);
        wake_clr = 6'h00;
        io_pin_in = 6'h05;
        cyc(6);
        chk(wake_flag, 8'h07, "wake edges");
        chk(dig_in, 8'h05, "digital in");
        chk(interrupt_output_n, 8'h0, "interrupt");
        tdone("wake");
        pulse(ext_rst_req);
        chk(reset_output_n, 8'h0, "fault reset");
        wait_rst();
        cyc(2);
        chk(rst_low_last >= 39 && rst_low_last <= 43, 8'h1, "reset length");
        chk(failsafe_init_phase, 8'h1, "back to init");
        io_pin_in = 6'h01;
        safe23_en = 1'b1;
        cyc(4);
        chk(pair_err[1], 8'h0, "pair idle in init");
        pulse(rst_dur_wr);
        chk(reset_duration_config, 8'h0, "duration rewritten");
        pulse(init_close);
        cyc(1);
        chk(pair_err[1], 8'h1, "pair error");
        chk(reset_output_n, 8'h0, "pair reset");
        wait_rst();
        cyc(2);
        chk(rst_low_last >= 19 && rst_low_last <= 23, 8'h1, "short reset");
        tdone("faults");
        safe23_en = 1'b0;
        boot(1'b1);
        chk(debug_mode, 8'h1, "debug");
        chk(can_normal_req, 8'h1, "can normal");
        release_fs();
        pulse(ext_fault);
        pulse(wd_error);
        cyc(2);
        chk({failsafe_output_n, reset_output_n}, 8'h3, "debug ignores");
        debug_win_in = 1'b0;
        cyc(5);
        chk(debug_mode, 8'h1, "debug kept");
        tdone("debug");
        io_pin_in = 6'h30;
        {safe01_en, safe45_en} = 2'h3;
        cyc(3);
        chk(pair_err, 8'h05, "ic pairs");
        chk({failsafe_output_n, reset_output_n}, 8'h2, "debug pair reset");
        tdone("ic pairs");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        final_report();
    end
endmodule : sio_top_tb_top
